// file: hw/cars_scheduler.sv
// Host scheduler that toggles integration select and reads back conversion results
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Drop transmit enable after ready, then clock bits
// - Shift clock idle 10 us around toggles
// - Before-toggle: start after ready, end before toggle
// - Before-toggle: stop pre-guard before select changes
// - Window is period minus delays; 40 clocks each
// - After-toggle: wait post-guard before any shift
// - After-toggle: finish before next data ready
// - Split: pause around toggle, finish before ready
// - Short period: whole noncontinuous window usable
// - Long period: wait for second integration end
// - Read second result before next round
// - Noncontinuous: keep guards; no ready deadline
// - Host gives first toggle to release integration
// - Wait 50 us init; integration 50 us later
module cars_scheduler #(
   parameter int CHAIN = 1,
   parameter int INT_CYC = cars_pkg::INT_PERIOD_CYC,
   parameter int POWER_CYC = cars_pkg::POWER_INIT_CYC,
   parameter int RELEASE_CYC = cars_pkg::RELEASE_INIT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic [1:0] method,
   input wire logic first_side,
   input wire logic result_ready_n,
   input wire logic serial_in,
   output logic integrator_side_select,
   output logic transmit_enable_n,
   output logic shift_clock,
   output logic [39:0] word_data,
   output logic word_valid,
   output logic word_last,
   output logic overrun,
   output logic running
);
   localparam int BITS = CHAIN * cars_pkg::BITS_PER_INTEGRATOR_SIDE_SELECT;

   cars_shift_if sif ();
   cars_shift_engine #(.HALF_CYC(cars_pkg::SHIFT_HALF_CYC)) u_eng (
      .clk(clk),
      .rst(rst),
      .sif(sif)
   );

   logic ready_s1_r;
   logic ready_s2_r;
   logic ready_prev_r;
   logic din_s1_r;
   logic din_s2_r;
   logic ready_fall;
   cars_pkg::cars_state_type state_r;
   cars_pkg::cars_state_type state_nxt;
   cars_pkg::cars_method_type method_r;
   logic [31:0] tick_r;
   logic [31:0] since_toggle_r;
   logic [31:0] bit_cnt_r;
   logic [5:0] word_bit_r;
   logic [39:0] shreg_r;
   logic select_r;
   logic xmit_n_r;
   logic toggle_now;
   logic guard_ok;
   logic word_valid_r;
   logic word_last_r;
   logic overrun_r;
   logic [31:0] power_cnt_r;
   logic [31:0] since_ready_r;
   logic late;
   logic [39:0] word_r;

   function automatic logic at_count(input logic [31:0] cnt, input int lim);
      at_count = cnt >= 32'(lim);
   endfunction

   // Readback holds transmit enable low in both of these states
   function automatic logic is_reading(input cars_pkg::cars_state_type st);
      is_reading = (st == cars_pkg::ST_SHIFT) || (st == cars_pkg::ST_PAUSE);
   endfunction

   // Integration select runs its period only once the release toggle is given
   function automatic logic is_released(input cars_pkg::cars_state_type st);
      is_released = (st != cars_pkg::ST_POWER) && (st != cars_pkg::ST_RELEASE);
   endfunction

   // Two-stage synchronisers for pins from the converter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready_s1_r <= 1'b1;
         ready_s2_r <= 1'b1;
         ready_prev_r <= 1'b1;
         din_s1_r <= 1'b0;
         din_s2_r <= 1'b0;
      end else begin
         ready_s1_r <= result_ready_n;
         ready_s2_r <= ready_s1_r;
         ready_prev_r <= ready_s2_r;
         din_s1_r <= serial_in;
         din_s2_r <= din_s1_r;
      end
   end
   assign ready_fall = ready_prev_r && !ready_s2_r;
   assign sif.data_in = din_s2_r;

   // Integration period timer; a toggle is due each time it wraps
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_r <= 32'h0000_0000;
      end else if (state_r == cars_pkg::ST_POWER || state_r == cars_pkg::ST_RELEASE) begin
         tick_r <= 32'h0000_0000;
      end else if (toggle_now) begin
         tick_r <= 32'h0000_0000;
      end else begin
         tick_r <= tick_r + 32'h0000_0001;
      end
   end

   // Toggle is held off while the shift clock is high, so no edge lands near it
   assign toggle_now = is_released(state_r) && at_count(tick_r, INT_CYC - 1)
      && !sif.busy;

   // Guard: far enough from the last toggle and from the next one
   assign guard_ok = at_count(since_toggle_r, cars_pkg::POST_GUARD_CYC)
      && !at_count(tick_r, INT_CYC - cars_pkg::PRE_GUARD_CYC - cars_pkg::SHIFT_HALF_CYC * 2);

   // Saturates past both waits, so the post-toggle guard can always be met
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         since_toggle_r <= 32'h0000_0000;
      end else if (toggle_now || state_r == cars_pkg::ST_RELEASE) begin
         since_toggle_r <= 32'h0000_0000;
      end else if (!at_count(since_toggle_r, RELEASE_CYC + cars_pkg::POST_GUARD_CYC)) begin
         since_toggle_r <= since_toggle_r + 32'h0000_0001;
      end
   end

   // Integration select: preset level at power, then first toggle releases it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         select_r <= cars_pkg::RST_SELECT;
         method_r <= cars_pkg::METHOD_BEFORE;
      end else if (state_r == cars_pkg::ST_POWER) begin
         // One steady level for the whole power wait picks the first side
         select_r <= first_side;
         method_r <= cars_pkg::cars_method_type'(method);
      end else if (state_r == cars_pkg::ST_RELEASE && at_count(tick_r, 0)
         && state_nxt != cars_pkg::ST_RELEASE) begin
         select_r <= ~select_r;
      end else if (toggle_now) begin
         select_r <= ~select_r;
      end
   end

   // Power-on wait has its own counter, so the bit counter starts clean
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_cnt_r <= 32'h0000_0000;
      end else if (state_r == cars_pkg::ST_POWER && !at_count(power_cnt_r, POWER_CYC)) begin
         power_cnt_r <= power_cnt_r + 32'h0000_0001;
      end
   end

   // Readback sequencer; one readback per fall of ready
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         cars_pkg::ST_POWER: begin
            if (enable && at_count(power_cnt_r, POWER_CYC)) begin
               state_nxt = cars_pkg::ST_RELEASE;
            end
         end
         cars_pkg::ST_RELEASE: begin
            state_nxt = cars_pkg::ST_WAIT_READY;
         end
         cars_pkg::ST_WAIT_READY: begin
            if (!enable) begin
               state_nxt = cars_pkg::ST_DONE;
            end else if (!ready_s2_r && at_count(since_toggle_r, RELEASE_CYC)) begin
               // After-toggle and split methods start only outside the guard
               if (guard_ok || method_r == cars_pkg::METHOD_BEFORE) begin
                  state_nxt = cars_pkg::ST_SHIFT;
               end
            end
         end
         cars_pkg::ST_SHIFT: begin
            if (at_count(bit_cnt_r, BITS) && !sif.busy) begin
               state_nxt = cars_pkg::ST_DONE;
            end else if (!guard_ok && !sif.busy) begin
               state_nxt = cars_pkg::ST_PAUSE;
            end
         end
         cars_pkg::ST_PAUSE: begin
            if (guard_ok) begin
               state_nxt = cars_pkg::ST_SHIFT;
            end
         end
         cars_pkg::ST_DONE: begin
            if (enable && ready_s2_r) begin
               state_nxt = cars_pkg::ST_WAIT_READY;
            end
         end
         default: state_nxt = cars_pkg::ST_POWER;
      endcase
   end

   // Single state register fed by the sequencer above
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= cars_pkg::ST_POWER;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Transmit enable falls on entering shift and rises when the word set is done
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xmit_n_r <= cars_pkg::RST_XMIT_N;
      end else if (state_nxt == cars_pkg::ST_SHIFT || state_nxt == cars_pkg::ST_PAUSE) begin
         xmit_n_r <= 1'b0;
      end else begin
         xmit_n_r <= 1'b1;
      end
   end

   // Shift clock only runs in ST_SHIFT with transmit enable already low
   assign sif.run = (state_r == cars_pkg::ST_SHIFT) && !xmit_n_r && guard_ok
      && !at_count(bit_cnt_r, BITS);

   // Bit counting and word assembly, one word per chained converter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_cnt_r <= 32'h0000_0000;
         word_bit_r <= 6'h00;
         shreg_r <= 40'h00_0000_0000;
         word_r <= 40'h00_0000_0000;
         word_valid_r <= 1'b0;
         word_last_r <= 1'b0;
      end else begin
         word_valid_r <= 1'b0;
         word_last_r <= 1'b0;
         // Cleared before each readback so chained words line up
         if (state_r == cars_pkg::ST_WAIT_READY || state_r == cars_pkg::ST_RELEASE) begin
            bit_cnt_r <= 32'h0000_0000;
            word_bit_r <= 6'h00;
         end else if (sif.bit_valid) begin
            bit_cnt_r <= bit_cnt_r + 32'h0000_0001;
            shreg_r <= {shreg_r[38:0], sif.bit_data};
            if (word_bit_r == 6'(cars_pkg::BITS_PER_INTEGRATOR_SIDE_SELECT - 1)) begin
               word_bit_r <= 6'h00;
               word_r <= {shreg_r[38:0], sif.bit_data};
               word_valid_r <= 1'b1;
               word_last_r <= at_count(bit_cnt_r, BITS - 1);
            end else begin
               word_bit_r <= word_bit_r + 6'h01;
            end
         end
      end
   end

   // Next result is due one period after this one; reading must end the quiet hold before it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         since_ready_r <= 32'h0000_0000;
      end else if (ready_fall) begin
         since_ready_r <= 32'h0000_0000;
      end else if (!at_count(since_ready_r, INT_CYC)) begin
         since_ready_r <= since_ready_r + 32'h0000_0001;
      end
   end
   // Noncontinuous pairs do not follow the period, so only continuous modes use it
   assign late = (method_r != cars_pkg::METHOD_NONCONT)
      && at_count(since_ready_r, INT_CYC - cars_pkg::READY_HOLD_CYC);

   // Overrun: a new result arrives, the ready deadline passes, or (before-toggle method only) a toggle is due, before the readback ended
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         overrun_r <= 1'b0;
      end else begin
         if (is_reading(state_r) && (ready_fall || late
            || (toggle_now && method_r == cars_pkg::METHOD_BEFORE))) begin
            overrun_r <= 1'b1;
         end else if (state_r == cars_pkg::ST_WAIT_READY && !enable) begin
            overrun_r <= 1'b0;
         end
      end
   end

   assign integrator_side_select = select_r;
   assign transmit_enable_n = xmit_n_r;
   assign shift_clock = sif.shift_level;
   assign word_data = word_r;
   assign word_valid = word_valid_r;
   assign word_last = word_last_r;
   assign overrun = overrun_r;
   assign running = is_released(state_r);
endmodule : cars_scheduler
`default_nettype wire

// file: hw/cars_pkg.sv
// Package of constants and types for the charge converter readback scheduler
package cars_pkg;
   // Clock rate of the scheduler
   localparam int CLK_HZ = 50000000;
   localparam int CLK_NS = 20;
   // Guard, hold and wait times in nanoseconds
   localparam int PRE_GUARD_NS = 10000;
   localparam int POST_GUARD_NS = 10000;
   localparam int READY_HOLD_NS = 2000;
   localparam int POWER_INIT_NS = 50000;
   localparam int RELEASE_INIT_NS = 50000;
   // Least times round up to whole cycles
   localparam int PRE_GUARD_CYC = (PRE_GUARD_NS + CLK_NS - 1) / CLK_NS;
   localparam int POST_GUARD_CYC = (POST_GUARD_NS + CLK_NS - 1) / CLK_NS;
   localparam int READY_HOLD_CYC = (READY_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int POWER_INIT_CYC = (POWER_INIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int RELEASE_INIT_CYC = (RELEASE_INIT_NS + CLK_NS - 1) / CLK_NS;
   // Bits per chained converter and shift clock half period in cycles
   localparam int BITS_PER_INTEGRATOR_SIDE_SELECT = 40;
   localparam int SHIFT_HALF_CYC = 4;
   // Default integration period in cycles (1000 us)
   localparam int INT_PERIOD_CYC = 50000;
   // Reset values of pins
   localparam logic RST_SELECT = 1'b0;
   localparam logic RST_XMIT_N = 1'b1;
   localparam logic RST_SHIFT = 1'b0;

   typedef enum logic [1:0] {
      METHOD_BEFORE = 2'b00,
      METHOD_AFTER = 2'b01,
      METHOD_SPLIT = 2'b10,
      METHOD_NONCONT = 2'b11
   } cars_method_type;

   typedef enum logic [2:0] {
      ST_POWER = 3'b000,
      ST_RELEASE = 3'b001,
      ST_WAIT_READY = 3'b010,
      ST_SHIFT = 3'b011,
      ST_PAUSE = 3'b100,
      ST_DONE = 3'b101
   } cars_state_type;
endpackage : cars_pkg

// file: hw/cars_shift_if.sv
// Interface joining the scheduler and its shift engine
`timescale 1ns/1ps
`default_nettype none
interface cars_shift_if;
   logic run;
   logic busy;
   logic bit_valid;
   logic bit_data;
   logic shift_level;
   logic data_in;
   modport ctrl (output run, input busy, input bit_valid, input bit_data, input shift_level,
      output data_in);
   modport eng (input run, output busy, output bit_valid, output bit_data, output shift_level,
      input data_in);
endinterface : cars_shift_if
`default_nettype wire

// file: hw/cars_shift_engine.sv
// Shift clock generator that clocks one bit per period while run is high
`timescale 1ns/1ps
`default_nettype none
module cars_shift_engine #(
   parameter int HALF_CYC = cars_pkg::SHIFT_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst,
   cars_shift_if.eng sif
);
   logic [7:0] div_r;
   logic level_r;
   logic valid_r;
   logic data_r;

   // Stopping mid-period holds the clock low, so a pause never leaves a half bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_r <= 8'h00;
         level_r <= cars_pkg::RST_SHIFT;
      end else if (!sif.run && !level_r) begin
         div_r <= 8'h00;
      end else if (div_r == 8'(HALF_CYC - 1)) begin
         div_r <= 8'h00;
         level_r <= ~level_r;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   // Sample serial data on the rising shift edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         valid_r <= 1'b0;
         data_r <= 1'b0;
      end else begin
         valid_r <= (div_r == 8'(HALF_CYC - 1)) && !level_r;
         if ((div_r == 8'(HALF_CYC - 1)) && !level_r) begin
            data_r <= sif.data_in;
         end
      end
   end

   assign sif.shift_level = level_r;
   assign sif.busy = level_r;
   assign sif.bit_valid = valid_r;
   assign sif.bit_data = data_r;
endmodule : cars_shift_engine
`default_nettype wire

// file: test/cars_scheduler_assertions.sv
// Port timing checker for the readback scheduler
`timescale 1ns/1ps
`default_nettype none
module cars_scheduler_assertions #(
   parameter int POWER_CYC = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic result_ready_n,
   input wire logic integrator_side_select,
   input wire logic transmit_enable_n,
   input wire logic shift_clock,
   input wire logic word_valid,
   input wire logic word_last
);
   logic sel_d_r;
   logic sclk_d_r;
   logic [15:0] since_tog_r;
   logic [15:0] since_shift_r;
   logic [15:0] since_rst_r;
   logic [15:0] rises_r;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Elapsed-time counters saturate, so long idle spans never wrap into a false pass
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_d_r <= cars_pkg::RST_SELECT;
         sclk_d_r <= 1'b0;
         since_tog_r <= 16'hFFFF;
         since_shift_r <= 16'hFFFF;
         since_rst_r <= 16'h0000;
         rises_r <= 16'h0000;
      end else begin
         sel_d_r <= integrator_side_select;
         sclk_d_r <= shift_clock;
         if (integrator_side_select != sel_d_r) since_tog_r <= 16'h0000;
         else if (since_tog_r != 16'hFFFF) since_tog_r <= since_tog_r + 16'h0001;
         if (shift_clock) since_shift_r <= 16'h0000;
         else if (since_shift_r != 16'hFFFF) since_shift_r <= since_shift_r + 16'h0001;
         if (since_rst_r != 16'hFFFF) since_rst_r <= since_rst_r + 16'h0001;
         if (transmit_enable_n) rises_r <= 16'h0000;
         else if (shift_clock && !sclk_d_r) rises_r <= rises_r + 16'h0001;
      end
   end
   sequence s_setup;
      !shift_clock [*4] ##1 shift_clock;
   endsequence
   sequence s_high;
      shift_clock [*4] ##1 !shift_clock;
   endsequence
   property p_post_guard;
      shift_clock |-> since_tog_r >= 16'(cars_pkg::POST_GUARD_CYC - 1);
   endproperty
   property p_pre_guard;
      $changed(integrator_side_select) |-> !shift_clock && since_shift_r >= 16'(cars_pkg::PRE_GUARD_CYC);
   endproperty
   property p_power;
      $changed(integrator_side_select) && since_rst_r != 16'h0001
         |-> since_rst_r >= 16'(POWER_CYC);
   endproperty
   property p_xmit_first;
      $rose(shift_clock) |-> !transmit_enable_n;
   endproperty
   property p_setup;
      $fell(transmit_enable_n) |-> s_setup;
   endproperty
   property p_high;
      $rose(shift_clock) |-> s_high;
   endproperty
   property p_ready;
      $fell(transmit_enable_n) |-> $past(result_ready_n, 2) == 1'b0;
   endproperty
   property p_idle;
      transmit_enable_n |-> !shift_clock;
   endproperty
   property p_pulse;
      word_valid |-> word_last ##1 !word_valid;
   endproperty
   property p_count;
      $rose(transmit_enable_n) |-> rises_r == 16'(cars_pkg::BITS_PER_INTEGRATOR_SIDE_SELECT);
   endproperty
   a_post_guard: assert property (p_post_guard) else $error("shift clock too soon after toggle");
   a_pre_guard: assert property (p_pre_guard) else $error("toggle too soon after shift clock");
   a_power: assert property (p_power) else $error("select moved during power-up");
   a_xmit_first: assert property (p_xmit_first) else $error("shift clock without transmit");
   a_setup: assert property (p_setup) else $error("first shift edge misplaced");
   a_high: assert property (p_high) else $error("shift clock high time wrong");
   a_ready: assert property (p_ready) else $error("readback without ready");
   a_idle: assert property (p_idle) else $error("shift clock outside readback");
   a_pulse: assert property (p_pulse) else $error("word strobe wrong");
   a_count: assert property (p_count) else $error("bit count per word wrong");
endmodule // cars_scheduler_assertions
`default_nettype wire

// file: test/cars_device_model.sv
// Behavioural model of the charge converter at the scheduler's far side
`timescale 1ns/1ps
`default_nettype none
module cars_device_model #(
   parameter int READY_DLY = 100
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic power_level,
   input wire logic select,
   input wire logic transmit_enable_n,
   input wire logic shift_clock,
   input wire logic [39:0] next_word,
   output logic result_ready_n,
   output logic serial_out
);
   logic released_r;
   logic sel_d_r;
   logic xmit_d_r;
   logic sclk_d_r;
   logic [15:0] dly_r;
   logic [39:0] sr_r;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         released_r <= 1'b0;
         sel_d_r <= 1'b0;
         xmit_d_r <= 1'b1;
         sclk_d_r <= 1'b0;
         dly_r <= 16'h0000;
         sr_r <= 40'h0;
         result_ready_n <= 1'b1;
         serial_out <= 1'b0;
      end else begin
         sel_d_r <= select;
         xmit_d_r <= transmit_enable_n;
         sclk_d_r <= shift_clock;
         // Side choice is the power-up level; leaving it is the release
         if (!released_r && select != sel_d_r && sel_d_r == power_level) begin
            released_r <= 1'b1;
         end
         if (released_r && select != sel_d_r) dly_r <= 16'(READY_DLY);
         else if (dly_r != 16'h0000) dly_r <= dly_r - 16'h0001;
         if (dly_r == 16'h0001) result_ready_n <= 1'b0;
         else if (!transmit_enable_n) result_ready_n <= 1'b1;
         // Released output churns so a stale level never looks valid
         if (transmit_enable_n) serial_out <= ~serial_out;
         else if (xmit_d_r) begin
            serial_out <= next_word[39];
            sr_r <= {next_word[38:0], 1'b0};
         end else if (sclk_d_r && !shift_clock) begin
            serial_out <= sr_r[39];
            sr_r <= {sr_r[38:0], 1'b0};
         end
      end
   end
endmodule // cars_device_model
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the readback scheduler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int POWER_CYC = 20;
   logic clk, rst, enable, first_side, result_ready_n, serial_in, sel, xmit_n, sclk;
   logic word_valid, word_last, overrun, running, rdy_d;
   logic [1:0] method;
   logic [39:0] word_data, next_word;
   logic [39:0] exp_q[$];
   int mismatches, n_compared, seed, words;
   cars_scheduler #(.CHAIN(1), .INT_CYC(2000), .POWER_CYC(POWER_CYC), .RELEASE_CYC(20))
      u_cars_scheduler (.clk(clk), .rst(rst), .enable(enable), .method(method),
      .first_side(first_side), .result_ready_n(result_ready_n), .serial_in(serial_in),
      .integrator_side_select(sel), .transmit_enable_n(xmit_n), .shift_clock(sclk),
      .word_data(word_data), .word_valid(word_valid), .word_last(word_last),
      .overrun(overrun), .running(running));
   cars_device_model #(.READY_DLY(600)) u_cars_device_model (.clk(clk), .rst(rst),
      .power_level(first_side), .select(sel), .transmit_enable_n(xmit_n),
      .shift_clock(sclk), .next_word(next_word), .result_ready_n(result_ready_n),
      .serial_out(serial_in));
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic run_method(input logic [1:0] m);
      int i;
      // Later calls land the reset in mid-readback
      for (i = 0; i < 2500 && xmit_n !== 1'b0; i++) @(negedge clk);
      rst = 1'b1;
      enable = 1'b0;
      method = m;
      first_side = 1'($random(seed));
      exp_q.delete();
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (100) @(negedge clk);
      check("running", {39'h0, running}, 40'h0);
      enable = 1'b1;
      words = 0;
      for (i = 0; i < 10000 && words < 3; i++) @(negedge clk);
      check("words", 40'(words), 40'h3);
      check("running", {39'h0, running}, 40'h1);
      check("overrun", {39'h0, overrun}, 40'h0);
      $display("test method %0d done", m);
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Each fresh result gets a random word, noted as the expected readback
   always @(negedge clk) begin
      rdy_d <= result_ready_n;
      if (rdy_d === 1'b1 && result_ready_n === 1'b0) begin
         next_word = {8'($random(seed)), 32'($random(seed))};
         exp_q.push_back(next_word);
      end
   end
   always @(negedge clk) begin
      if (word_valid === 1'b1) begin
         words++;
         if (exp_q.size() == 0) check("unexpected word", word_data, 40'h0);
         else check("word", word_data, exp_q.pop_front());
         check("last", {39'h0, word_last}, 40'h1);
      end
   end
   initial begin
      #1000000;
      mismatches++;
      print_verdict();
   end
   initial begin
      seed = 43369;
      mismatches = 0;
      n_compared = 0;
      rst = 1'b1;
      enable = 1'b0;
      method = 2'h0;
      first_side = 1'b0;
      next_word = 40'h0;
      rdy_d = 1'b1;
      run_method(2'h0);
      run_method(2'h1);
      run_method(2'h2);
      run_method(2'h3);
      print_verdict();
   end
endmodule // tb_top
bind cars_scheduler cars_scheduler_assertions #(.POWER_CYC(POWER_CYC))
   u_cars_scheduler_assertions (.clk(clk), .rst(rst), .result_ready_n(result_ready_n),
   .integrator_side_select(integrator_side_select), .transmit_enable_n(transmit_enable_n),
   .shift_clock(shift_clock), .word_valid(word_valid), .word_last(word_last));
`default_nettype wire
